/* File: dv/core_pins_model.sv */
`timescale 1ns/1ps
module core_pins_model (
  // Clock
  input wire logic pclk,
  // Towards the block
  output trap_irq_pkg::trap_evt_t trap_evt,
  output logic irq_deferral_active,
  output logic [2:0] ext_irq_pin
);
  // Quiet core, pins low
  initial begin
    trap_evt = '0;
    irq_deferral_active = 1'b0;
    ext_irq_pin = 3'h0;
  end
  // Trap sources are one-cycle pulses
  task automatic trap(input logic [2:0] t);
    @(posedge pclk) trap_evt <= t;
    @(posedge pclk) trap_evt <= '0;
  endtask : trap
  // Pin levels hold until changed
  task automatic pins(input logic [2:0] p);
    @(posedge pclk) ext_irq_pin <= p;
  endtask : pins
  task automatic defer(input logic d);
    @(posedge pclk) irq_deferral_active <= d;
  endtask : defer
endmodule : core_pins_model

/* File: dv/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  localparam logic [11:0] TS = trap_irq_pkg::OFF_TRAP_STATUS;
  localparam logic [11:0] GC = trap_irq_pkg::OFF_GLOBAL_CTRL;
  localparam logic [11:0] ES = trap_irq_pkg::OFF_IRQ_STATUS;
  localparam logic [11:0] EM = trap_irq_pkg::OFF_IRQ_MASK;
  // Bench-driven inputs
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  // Outputs and model pins
  logic [31:0] prdata;
  logic pready, pslverr, irq, trap_pending, soft_trap_req;
  logic alt_vector_select, global_irq_enable, irq_deferral_active;
  logic [2:0] ext_irq_pin, ext_irq_req;
  trap_irq_pkg::trap_evt_t trap_evt;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [32:0] exp_q[$];
  logic [31:0] seed = 32'h0000_5d93;
  logic [31:0] v;
  always #12.5 pclk = ~pclk;
  trap_irq_ctrl dut_u (.*);
  core_pins_model model_u (.*);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input string s, input logic [32:0] e, input logic [32:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask : settle
  // One APB transfer; the note is queued before the bus moves
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    exp_q.push_back(e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : bus
  task automatic finish_test();
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : finish_test
  // Completed transfers against the oldest note; hang limit
  always @(posedge pclk) begin
    cycles++;
    if (psel && penable && pready === 1'b1)
      chk("apb", exp_q.pop_front(), {pslverr, pwrite ? 32'h0000_0000 : prdata});
    if (cycles == 3000) begin
      failures++;
      finish_test();
    end
  end
  // Main sequence
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    bus(1'b0, TS, 0, 0);
    bus(1'b0, GC, 0, 32'h0000_8000);
    bus(1'b0, EM, 0, 0);
    for (int i = 0; i < 3; i++) begin
      model_u.trap(3'h1 << i);
      bus(1'b0, TS, 0, (32'h0000_0004 << i) - 32'h0000_0002);
    end
    chk("pending", 1'b1, trap_pending);
    settle(5);
    bus(1'b1, TS, 32'hffff_ffff, 0);
    bus(1'b0, TS, 0, 32'h0000_000e);
    bus(1'b1, TS, 0, 0);
    bus(1'b0, TS, 0, 0);
    model_u.defer(1'b1);
    // Random control words; deferral stays visible
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      bus(1'b1, GC, seed, 0);
      bus(1'b0, GC, 0, (seed & 32'h0000_a107) | 32'h0000_4000);
      chk("ctl", {seed[15], seed[13], seed[8]},
          {global_irq_enable, soft_trap_req, alt_vector_select});
    end
    model_u.defer(1'b0);
    // Mixed polarities; wanted edge counts, opposite edge does not
    for (int k = 0; k < 2; k++) begin
      v = k ? 32'h0000_8002 : 32'h0000_8005;
      bus(1'b1, GC, v, 0);
      bus(1'b0, GC, 0, v);
      model_u.pins(v[2:0]);
      settle(5);
      bus(1'b1, ES, 32'h0000_007f, 0);
      model_u.pins(~v[2:0]);
      settle(5);
      bus(1'b0, ES, 0, 32'h0000_0007);
      chk("ext", 3'h7, ext_irq_req);
      bus(1'b1, ES, 32'h0000_007f, 0);
      model_u.pins(v[2:0]);
      settle(5);
      bus(1'b0, ES, 0, 0);
    end
    bus(1'b1, EM, 32'h0000_007f, 0);
    bus(1'b0, EM, 0, 32'h0000_007f);
    model_u.pins(3'h5);
    settle(5);
    chk("irq", 1'b1, irq);
    bus(1'b1, GC, 32'h0000_0002, 0);
    settle(2);
    chk("irq", 1'b0, irq);
    model_u.trap(3'h4);
    settle(2);
    chk("irq", 1'b1, irq);
    bus(1'b1, 12'h010, 32'hffff_ffff, 33'h1_0000_0000);
    bus(1'b0, 12'h010, 0, 33'h1_0000_0000);
    // One more edge so the watcher compares the last transfer before the close
    @(posedge pclk);
    if (exp_q.size() != 0) begin
      failures++;
      $display("[ERR] notes left expected 0 seen %0d", exp_q.size());
    end
    finish_test();
  end
endmodule : tb_top

/* File: dv/trap_irq_assertions.sv */
`timescale 1ns/1ps
module trap_irq_checker (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave side
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Core and pins
  input wire trap_irq_pkg::trap_evt_t trap_evt,
  input wire logic irq_deferral_active,
  input wire logic [2:0] ext_irq_pin,
  input wire logic [2:0] ext_irq_req,
  input wire logic trap_pending,
  input wire logic soft_trap_req,
  input wire logic alt_vector_select,
  input wire logic global_irq_enable,
  input wire logic irq
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Phase decode; read data is captured at setup, shown in access
  wire rd_s = psel && !penable && !pwrite;
  wire rd_a = psel && penable && !pwrite;
  wire wr_a = psel && penable && pwrite;
  wire ts_s = paddr[11:2] == 10'h000;
  wire gc_s = paddr[11:2] == 10'h001;
  chk_addr_fault_set: assert property (trap_evt.addr_fault |=> trap_pending)
    else $error("addr fault lost");
  chk_stack_fault_set: assert property (trap_evt.stack_fault |=> trap_pending)
    else $error("stack fault lost");
  chk_clock_loss_set: assert property (trap_evt.clock_loss |=> trap_pending)
    else $error("clock loss lost");
  chk_status_bit0: assert property (rd_a && ts_s |-> prdata[0] == 1'b0)
    else $error("status bit0 set");
  chk_defer_bit: assert property (
    rd_s && gc_s |=> prdata[14] == $past(irq_deferral_active))
    else $error("deferral bit wrong");
  chk_alt_vec_write: assert property (
    wr_a && gc_s |=> alt_vector_select == $past(pwdata[8]))
    else $error("alt vector not written");
  chk_gie_gate: assert property (!global_irq_enable |-> ext_irq_req == 3'h0)
    else $error("ext request while disabled");
  chk_ctrl_unused: assert property (
    rd_a && gc_s |-> prdata[12:9] == 4'h0 && prdata[7:3] == 5'h0)
    else $error("unused control bits set");
  chk_trap_sticky: assert property (trap_pending && !wr_a |=> trap_pending)
    else $error("trap pending dropped");
endmodule : trap_irq_checker
bind trap_irq_ctrl trap_irq_checker chk_u (.*);

/* File: hdl/edge_sense.sv */
`timescale 1ns/1ps
// Synchronises one pin and flags the selected edge as a one-cycle pulse
module edge_sense (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pin and polarity
  input wire logic pin,
  input wire logic falling_sel,
  // Edge pulse
  output logic edge_pulse
);

  logic meta_r;
  logic sync_r;
  logic prev_r;

  // Two-stage synchroniser, then a history stage for edge compare
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= pin;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // Polarity picks falling (1) or rising (0) edge
  assign edge_pulse = falling_sel ? (prev_r & ~sync_r) : (sync_r & ~prev_r);

endmodule : edge_sense

/* File: hdl/sticky_bits.sv */
`timescale 1ns/1ps
// Bank of sticky flags; a set in the clear cycle wins
module sticky_bits #(
  parameter int W = 3
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Set and clear strobes
  input wire logic [W-1:0] set_bits,
  input wire logic [W-1:0] clr_bits,
  // Held flags
  output logic [W-1:0] flags
);

  logic [W-1:0] flags_r;
  logic [W-1:0] flags_nxt;

  // Set beats clear so no event is lost
  assign flags_nxt = (flags_r & ~clr_bits) | set_bits;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_r <= '0;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  assign flags = flags_r;

endmodule : sticky_bits

/* File: hdl/trap_irq_ctrl.sv */
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
// Function
// - An address error trap sets the address fault flag in trap status bit 3.
// - A stack error trap sets the stack fault flag in trap status bit 2.
// - An oscillator failure trap sets the clock loss flag in trap status bit 1.
// - Trap status bit 0 always reads zero and ignores writes.
// - Global control bit 14 reports read-only whether interrupt deferral is active.
// - Global control bit 13 is the soft trap enable, reset 0, writing 1 raises it.
// - Global control bit 8 selects the alternate vector table, reset 0.
// - Global control bits 2..0 are edge polarity selects for external inputs 2..0, reset 0.
// - A polarity bit of 1 requests on a falling edge, 0 on a rising edge.
module trap_irq_ctrl (
  // APB clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Trap sources and deferral status from the core
  input wire trap_irq_pkg::trap_evt_t trap_evt,
  input wire logic irq_deferral_active,
  // External interrupt pins
  input wire logic [2:0] ext_irq_pin,
  // Towards the core
  output logic [2:0] ext_irq_req,
  output logic trap_pending,
  output logic soft_trap_req,
  output logic alt_vector_select,
  output logic global_irq_enable,
  // Interrupt line
  output logic irq
);

  // Decode of an address against one register offset
  function automatic logic reg_hit(input logic [11:0] addr, input logic [11:0] offset);
    reg_hit = (addr[11:2] == offset[11:2]);
  endfunction : reg_hit

  trap_irq_pkg::apb_req_t req;

  // Control registers
  logic irq_enable_r;
  logic soft_trap_r;
  logic alt_vector_r;
  logic [2:0] edge_sel_r;
  logic [6:0] evt_mask_r;
  logic [31:0] prdata_r;

  logic irq_enable_nxt;
  logic soft_trap_nxt;
  logic alt_vector_nxt;
  logic [2:0] edge_sel_nxt;
  logic [6:0] evt_mask_nxt;
  logic [31:0] prdata_nxt;

  // Flags and events
  logic [2:0] trap_set;
  logic [2:0] trap_clr;
  logic [2:0] trap_flags;
  logic [2:0] ext_edge;
  logic [6:0] evt_set;
  logic [6:0] evt_clr;
  logic [6:0] evt_flags;
  logic [6:0] evt_active;
  logic soft_trap_rise;

  // Bus decode
  logic setup_phase;
  logic access_phase;
  logic hit_trap;
  logic hit_ctrl;
  logic hit_evt;
  logic hit_mask;
  logic hit_any;
  logic wr_trap;
  logic wr_ctrl;
  logic wr_evt;
  logic wr_mask;

  // Read views
  logic [15:0] trap_view;
  logic [15:0] ctrl_view;
  logic [15:0] evt_view;
  logic [15:0] mask_view;
  logic [15:0] rd_mux;

  // Bundle the request fields
  assign req.addr = paddr;
  assign req.write = pwrite;
  assign req.wdata = pwdata;

  // Phase and address decode
  assign setup_phase = psel & ~penable;
  assign access_phase = psel & penable;
  assign hit_trap = reg_hit(req.addr, trap_irq_pkg::OFF_TRAP_STATUS);
  assign hit_ctrl = reg_hit(req.addr, trap_irq_pkg::OFF_GLOBAL_CTRL);
  assign hit_evt = reg_hit(req.addr, trap_irq_pkg::OFF_IRQ_STATUS);
  assign hit_mask = reg_hit(req.addr, trap_irq_pkg::OFF_IRQ_MASK);
  assign hit_any = hit_trap | hit_ctrl | hit_evt | hit_mask;

  // Writes land only at the access edge
  assign wr_trap = access_phase & req.write & hit_trap;
  assign wr_ctrl = access_phase & req.write & hit_ctrl;
  assign wr_evt = access_phase & req.write & hit_evt;
  assign wr_mask = access_phase & req.write & hit_mask;

  // Zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = access_phase & ~hit_any;

  // External pins: synchronise and pick the edge per polarity bit
  genvar gi;
  generate
    for (gi = 0; gi < trap_irq_pkg::EXT_N; gi++) begin : g_ext
      edge_sense u_edge (
        .pclk(pclk),
        .presetn(presetn),
        .pin(ext_irq_pin[gi]),
        .falling_sel(edge_sel_r[gi]),
        .edge_pulse(ext_edge[gi])
      );
    end
  endgenerate

  // Trap pulses set the sticky flags
  assign trap_set[2] = trap_evt.addr_fault;
  assign trap_set[1] = trap_evt.stack_fault;
  assign trap_set[0] = trap_evt.clock_loss;

  // Software clears a trap flag by writing 0 to it; writing 1 keeps it
  assign trap_clr = {3{wr_trap}} & ~req.wdata[trap_irq_pkg::TS_ADDR_FAULT:1];

  sticky_bits #(
    .W(trap_irq_pkg::TRAP_N)
  ) u_trap_flags (
    .pclk(pclk),
    .presetn(presetn),
    .set_bits(trap_set),
    .clr_bits(trap_clr),
    .flags(trap_flags)
  );

  // Soft trap raised on a 0 to 1 write of its enable
  assign soft_trap_rise = soft_trap_nxt & ~soft_trap_r;

  // Event status: pins, traps and soft trap; write one to clear
  assign evt_set = {soft_trap_rise, trap_set, ext_edge};
  assign evt_clr = {7{wr_evt}} & req.wdata[6:0];

  sticky_bits #(
    .W(trap_irq_pkg::EVT_W)
  ) u_evt_flags (
    .pclk(pclk),
    .presetn(presetn),
    .set_bits(evt_set),
    .clr_bits(evt_clr),
    .flags(evt_flags)
  );

  // Next values for the writable control fields
  assign irq_enable_nxt = wr_ctrl ? req.wdata[trap_irq_pkg::GC_IRQ_ENABLE] : irq_enable_r;
  assign soft_trap_nxt = wr_ctrl ? req.wdata[trap_irq_pkg::GC_SOFT_TRAP] : soft_trap_r;
  assign alt_vector_nxt = wr_ctrl ? req.wdata[trap_irq_pkg::GC_ALT_VECTOR] : alt_vector_r;
  assign edge_sel_nxt = wr_ctrl ? req.wdata[2:0] : edge_sel_r;
  assign evt_mask_nxt = wr_mask ? req.wdata[6:0] : evt_mask_r;

  // Control register bank
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_enable_r <= trap_irq_pkg::RST_IRQ_ENABLE;
      soft_trap_r <= trap_irq_pkg::RST_SOFT_TRAP;
      alt_vector_r <= trap_irq_pkg::RST_ALT_VECTOR;
      edge_sel_r <= trap_irq_pkg::RST_EDGE_SEL;
      evt_mask_r <= trap_irq_pkg::RST_EVT_MASK;
    end else begin
      irq_enable_r <= irq_enable_nxt;
      soft_trap_r <= soft_trap_nxt;
      alt_vector_r <= alt_vector_nxt;
      edge_sel_r <= edge_sel_nxt;
      evt_mask_r <= evt_mask_nxt;
    end
  end

  // Trap status view; bit 0 and upper bits tied low
  assign trap_view = {12'h000, trap_flags, 1'b0};

  // Global control view; unused fields read zero
  assign ctrl_view = {irq_enable_r,
                      irq_deferral_active,
                      soft_trap_r,
                      4'h0,
                      alt_vector_r,
                      5'h00,
                      edge_sel_r};

  assign evt_view = {9'h000, evt_flags};
  assign mask_view = {9'h000, evt_mask_r};

  // Read selection
  assign rd_mux = hit_trap ? trap_view :
                  hit_ctrl ? ctrl_view :
                  hit_evt ? evt_view :
                  hit_mask ? mask_view : 16'h0000;

  // Read data is captured in setup so it comes from a flop at the access edge
  assign prdata_nxt = (setup_phase & ~req.write) ? {16'h0000, rd_mux} : prdata_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= trap_irq_pkg::RST_PRDATA;
    end else begin
      prdata_r <= prdata_nxt;
    end
  end

  assign prdata = prdata_r;

  // Pending events after the mask
  assign evt_active = evt_flags & evt_mask_r;

  // Maskable pin requests gated by the global enable; traps are not
  assign ext_irq_req = evt_flags[2:0] & {3{irq_enable_r}};
  assign trap_pending = (|trap_flags) | soft_trap_r;
  assign irq = ((|evt_active[2:0]) & irq_enable_r) | (|evt_active[6:3]);

  // Plain control levels out to the core
  assign soft_trap_req = soft_trap_r;
  assign alt_vector_select = alt_vector_r;
  assign global_irq_enable = irq_enable_r;

endmodule : trap_irq_ctrl

/* File: hdl/trap_irq_pkg.sv */
package trap_irq_pkg;

  // Register byte offsets on the APB window
  localparam logic [11:0] OFF_TRAP_STATUS = 12'h000;
  localparam logic [11:0] OFF_GLOBAL_CTRL = 12'h004;
  localparam logic [11:0] OFF_IRQ_STATUS = 12'h008;
  localparam logic [11:0] OFF_IRQ_MASK = 12'h00c;

  // Register widths
  localparam int REG_W = 16;
  localparam int EXT_N = 3;
  localparam int TRAP_N = 3;
  localparam int EVT_W = 7;

  // Trap status field positions
  localparam int TS_ADDR_FAULT = 3;
  localparam int TS_STACK_FAULT = 2;
  localparam int TS_CLOCK_LOSS = 1;

  // Global control field positions
  localparam int GC_IRQ_ENABLE = 15;
  localparam int GC_DEFERRAL = 14;
  localparam int GC_SOFT_TRAP = 13;
  localparam int GC_ALT_VECTOR = 8;
  localparam int GC_EDGE_SEL_LSB = 0;

  // Event status and mask field positions
  localparam int EV_EXT_LSB = 0;
  localparam int EV_TRAP_LSB = 3;
  localparam int EV_SOFT_TRAP = 6;

  // Reset values
  localparam logic RST_IRQ_ENABLE = 1'b1;
  localparam logic RST_SOFT_TRAP = 1'b0;
  localparam logic RST_ALT_VECTOR = 1'b0;
  localparam logic [EXT_N-1:0] RST_EDGE_SEL = 3'h0;
  localparam logic [EVT_W-1:0] RST_EVT_MASK = 7'h00;
  localparam logic [31:0] RST_PRDATA = 32'h0000_0000;

  // One APB request as seen in the setup phase
  typedef struct packed {
    logic [11:0] addr;
    logic write;
    logic [31:0] wdata;
  } apb_req_t;

  // Trap sources from the core, one-cycle pulses
  typedef struct packed {
    logic addr_fault;
    logic stack_fault;
    logic clock_loss;
  } trap_evt_t;

endpackage : trap_irq_pkg
